/* File: isp_regs.svh */
// register map, field positions, reset values and timing figures
`ifndef ISP_REGS_SVH
`define ISP_REGS_SVH

// register byte offsets
`define ISP_A_CFG5 8'h00
`define ISP_A_CFG6 8'h04
`define ISP_A_OUTCTL 8'h08
`define ISP_A_STATUS 8'h0C
`define ISP_A_MASK 8'h10
`define ISP_A_PER5 8'h14
`define ISP_A_DUTY5 8'h18
`define ISP_A_PER6 8'h1C
`define ISP_A_DUTY6 8'h20

// pin configuration fields
`define ISP_F_FN_HI 1
`define ISP_F_FN_LO 0
`define ISP_F_INV 2
`define ISP_F_OSEL_HI 4
`define ISP_F_OSEL_LO 3
`define ISP_CFG_W 5

// output control write bits and read bits
`define ISP_C_ON 0
`define ISP_C_OFF 1
`define ISP_C_CLR 2
`define ISP_R_ON 0
`define ISP_R_DRV 1
`define ISP_R_INH 2
`define ISP_R_PROT 3
`define ISP_R_G5 4
`define ISP_R_G6 5

// status and mask bits
`define ISP_S_TRIP 0
`define ISP_S_SYNC_IN 1
`define ISP_S_SYNC_OUT 2
`define ISP_S_INH 3
`define ISP_ST_W 4

// reset values
`define ISP_RST_CFG 5'h00
`define ISP_RST_MASK 4'h0
`define ISP_RST_PER 16'h03E8
`define ISP_RST_DUTY 16'h01F4
`define ISP_RST_SYNC 2'h3

// timing figures
`define ISP_CLK_MHZ 25
`define ISP_LOW_MIN_NS 30000
`define ISP_SYNC_OUT_NS 40000
`define ISP_PWM_TICK_NS 1000
`define ISP_CNT_W 12
`define ISP_PRE_W 8

`endif

/* File: isp_pkg.sv */
// types shared by the pin logic and its pwm generator
`default_nettype none
`include "isp_regs.svh"
package isp_pkg;
  typedef enum logic [1:0] {P5_LEVEL, P5_LATCH, P5_INPUT, P5_OUTPUT} isp_p5_fn_e;
  typedef enum logic [1:0] {P6_SYNC, P6_INPUT, P6_OUTPUT} isp_p6_fn_e;
  typedef enum logic [1:0] {OS_TRUE, OS_FALSE, OS_PWM} isp_osel_e;
  typedef enum logic {SO_IDLE, SO_DRIVE} isp_so_e;

  typedef struct packed {
    logic [15:0] cnt;
    logic pwm;
  } isp_pwm_s;

  typedef struct packed {
    logic [`ISP_CFG_W-1:0] cfg5;
    logic [`ISP_CFG_W-1:0] cfg6;
    logic [15:0] per5;
    logic [15:0] duty5;
    logic [15:0] per6;
    logic [15:0] duty6;
    logic [`ISP_ST_W-1:0] status;
    logic [`ISP_ST_W-1:0] mask;
    logic on;
    logic prot;
    logic level_inhibit_indication;
    logic drive;
    logic [1:0] s5;
    logic [1:0] s6;
    logic [`ISP_CNT_W-1:0] q5;
    logic [`ISP_CNT_W-1:0] q6;
    logic [`ISP_CNT_W-1:0] so_cnt;
    isp_so_e so_st;
    logic [`ISP_PRE_W-1:0] pre;
    logic tick;
    logic g5;
    logic g6;
    logic [31:0] rdata;
    logic irq;
    logic p5_o;
    logic p5_oe;
    logic p6_o;
    logic p6_oe;
  } isp_state_s;
endpackage
`default_nettype wire

/* File: isp_pwm.sv */
// pwm generator stepping on a prescaler tick
`timescale 1ns/1ps
`default_nettype none
module isp_pwm
  import isp_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic tick, // one-cycle step enable
  input wire logic [15:0] period, // ticks per pwm period
  input wire logic [15:0] duty, // ticks high per period
  output logic pwm_o // registered waveform
);
  isp_pwm_s r;
  isp_pwm_s n;

  // counter wraps at period; a period of zero holds the output low
  always_comb begin
    n = r;
    if (tick) begin
      if (r.cnt >= period - 16'h0001) begin
        n.cnt = 16'h0000;
      end else begin
        n.cnt = r.cnt + 16'h0001;
      end
    end
    n.pwm = (period != 16'h0000) && (n.cnt < duty);
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign pwm_o = r.pwm;
endmodule
`default_nettype wire

/* File: isp_top.sv */
// inhibit pin and sync turn-on pin logic with register port
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "isp_regs.svh"
module isp_top
  import isp_pkg::*;
(
  input wire logic REF_CLK, // 25 MHz clock
  input wire logic RST, // synchronous reset, active high
  input wire logic [7:0] ADDR, // register byte address
  input wire logic [31:0] WDATA, // write data
  input wire logic WR, // write strobe
  input wire logic RD, // read strobe
  output logic [31:0] RDATA, // read data, cycle after RD
  output logic IRQ, // level interrupt
  output logic OUT_ON, // on state and its indicator
  output logic OUT_DRIVE, // actual output allowed
  output logic INH_IND, // level inhibit indication
  output logic PROT_IND, // latched inhibit protection indication
  input wire logic P5_I, // inhibit pin level in
  output logic P5_O, // inhibit pin level out
  output logic P5_OE, // inhibit pin drive enable
  input wire logic P6_I, // sync pin level in
  output logic P6_O, // sync pin level out
  output logic P6_OE // sync pin drive enable
);
  // minimum low rounds up, the emitted pulse is a longer figure
  // rounding up errs towards refusing a marginal pulse rather than
  // accepting one shorter than the minimum
  localparam int LOW_INT = (`ISP_LOW_MIN_NS * `ISP_CLK_MHZ + 999) / 1000;
  localparam int SO_INT = (`ISP_SYNC_OUT_NS * `ISP_CLK_MHZ + 999) / 1000;
  localparam int PRE_INT = (`ISP_PWM_TICK_NS * `ISP_CLK_MHZ + 999) / 1000;
  localparam logic [`ISP_CNT_W-1:0] LOW_CYC = `ISP_CNT_W'(LOW_INT);
  localparam logic [`ISP_CNT_W-1:0] SO_CYC = `ISP_CNT_W'(SO_INT);
  localparam logic [`ISP_PRE_W-1:0] PRE_CYC = `ISP_PRE_W'(PRE_INT);

  // registered state and its next value, one struct for the whole block
  isp_state_s r;
  isp_state_s n;
  // generator waveforms, each already from a register
  logic pwm5;
  logic pwm6;

  // pin polarity: logic one is a low level unless inverted
  // one mapping serves inputs and outputs, so inversion stays symmetric
  function automatic logic polar(input logic lvl, input logic inv);
    polar = inv ? lvl : ~lvl;
  endfunction

  // level to drive for an output selection
  function automatic logic out_lvl(input logic [1:0] sel, input logic pw,
                                   input logic inv);
    logic v;
    v = 1'b0;
    case (isp_osel_e'(sel))
      OS_TRUE: v = 1'b1;
      OS_FALSE: v = 1'b0;
      OS_PWM: v = pw;
      default: v = 1'b0;
    endcase
    out_lvl = polar(v, inv);
  endfunction

  // active-time counter, saturating once the minimum is met
  // saturation stops a pin held low for long from firing twice
  function automatic logic [`ISP_CNT_W-1:0] qual_next(
      input logic [`ISP_CNT_W-1:0] c, input logic act);
    if (!act) begin
      qual_next = '0;
    end else if (c == LOW_CYC) begin
      qual_next = c;
    end else begin
      qual_next = c + `ISP_CNT_W'(1);
    end
  endfunction

  // one pulse per qualifying active phase, at the moment it is long enough
  function automatic logic qual_fire(input logic [`ISP_CNT_W-1:0] c,
                                     input logic act);
    qual_fire = act && (c == LOW_CYC - `ISP_CNT_W'(1));
  endfunction

  // one pwm generator per pin, sharing the prescaler tick
  isp_pwm u_pwm5 (
    .clk(REF_CLK),
    .rst(RST),
    .tick(r.tick),
    .period(r.per5),
    .duty(r.duty5),
    .pwm_o(pwm5)
  );

  isp_pwm u_pwm6 (
    .clk(REF_CLK),
    .rst(RST),
    .tick(r.tick),
    .period(r.per6),
    .duty(r.duty6),
    .pwm_o(pwm6)
  );

  // decoded configuration and synchronised pin activity
  logic inv5;
  logic inv6;
  isp_p5_fn_e fn5;
  isp_p6_fn_e fn6;
  logic act5;
  logic act6;
  logic lvl_inh;
  logic fire5;
  logic fire6;

  // register-port commands and the causes that move the on state
  logic wr_ctl;
  logic loc_on;
  logic loc_off;
  logic clr;
  logic trip;
  logic sync_on;
  logic turn_on;
  logic force_off;
  logic emit;

  // status read strobe and the events of the current cycle
  logic rd_st;
  logic [`ISP_ST_W-1:0] ev;

  // decode of configuration and the synchronised pin levels
  always_comb begin
    inv5 = r.cfg5[`ISP_F_INV];
    inv6 = r.cfg6[`ISP_F_INV];
    fn5 = isp_p5_fn_e'(r.cfg5[`ISP_F_FN_HI:`ISP_F_FN_LO]);
    fn6 = isp_p6_fn_e'(r.cfg6[`ISP_F_FN_HI:`ISP_F_FN_LO]);
    act5 = polar(r.s5[1], inv5);
    // own emitted pulse is masked so the pin never re-triggers itself
    act6 = polar(r.s6[1], inv6) && (r.so_st == SO_IDLE);
    lvl_inh = (fn5 == P5_LEVEL) && act5;
    fire5 = qual_fire(r.q5, act5 && (fn5 == P5_LATCH));
    fire6 = qual_fire(r.q6, act6 && (fn6 == P6_SYNC));
  end

  // on/off decisions; off causes take priority over turn-on causes
  // one write may carry several command bits; off still wins
  always_comb begin
    wr_ctl = WR && (ADDR == `ISP_A_OUTCTL);
    loc_on = wr_ctl && WDATA[`ISP_C_ON];
    loc_off = wr_ctl && WDATA[`ISP_C_OFF];
    clr = wr_ctl && WDATA[`ISP_C_CLR];
    trip = fire5 && r.on;
    force_off = loc_off || trip;
    // protection blocks turn-on; a clear in the same write lifts it
    turn_on = loc_on && !r.on && !(r.prot && !clr) && !force_off;
    sync_on = fire6 && !r.on && !(r.prot && !clr) && !force_off;
    emit = turn_on && (fn6 == P6_SYNC);
    rd_st = RD && (ADDR == `ISP_A_STATUS);
  end

  // next state of the whole block
  always_comb begin
    n = r;
    ev = '0;

    // two-stage synchronisers; only the second stage is looked at
    n.s5 = {r.s5[0], P5_I};
    n.s6 = {r.s6[0], P6_I};
    n.q5 = qual_next(r.q5, act5 && (fn5 == P5_LATCH));
    n.q6 = qual_next(r.q6, act6 && (fn6 == P6_SYNC));

    // prescaler for the pwm step enable
    // one shared step keeps both generators on a common time base
    n.tick = (r.pre == PRE_CYC - `ISP_PRE_W'(1));
    n.pre = n.tick ? '0 : r.pre + `ISP_PRE_W'(1);

    // register writes
    // unmapped writes fall through and change nothing
    if (WR) begin
      case (ADDR)
        `ISP_A_CFG5: n.cfg5 = WDATA[`ISP_CFG_W-1:0];
        `ISP_A_CFG6: n.cfg6 = WDATA[`ISP_CFG_W-1:0];
        `ISP_A_MASK: n.mask = WDATA[`ISP_ST_W-1:0];
        `ISP_A_PER5: n.per5 = WDATA[15:0];
        `ISP_A_DUTY5: n.duty5 = WDATA[15:0];
        `ISP_A_PER6: n.per6 = WDATA[15:0];
        `ISP_A_DUTY6: n.duty6 = WDATA[15:0];
        default: n.cfg5 = r.cfg5;
      endcase
    end

    // on state; a missing pulse leaves it untouched
    // a trip beside a local turn-on leaves the output off
    if (force_off) begin
      n.on = 1'b0;
    end else if (turn_on || sync_on) begin
      n.on = 1'b1;
    end else begin
      n.on = r.on;
    end

    // protection latch, set wins over a clear in the same cycle
    // a clear alone does not turn on; the operator must do that
    n.prot = (r.prot && !clr) || trip;

    // level inhibit suppresses the output but not the on state
    // drive follows the pin, so release restores the setpoint unaided
    n.level_inhibit_indication = r.on && !force_off && lvl_inh;
    n.drive = n.on && !lvl_inh;

    // general inputs follow the pin only in input mode
    // reading zero elsewhere keeps stale pin levels off the bus
    n.g5 = (fn5 == P5_INPUT) ? act5 : 1'b0;
    n.g6 = (fn6 == P6_INPUT) ? polar(r.s6[1], inv6) : 1'b0;

    // sync pulse emitter, held longer than the minimum low phase
    // the margin lets a peer with slow edges still qualify the pulse
    case (r.so_st)
      SO_IDLE: begin
        n.so_cnt = '0;
        if (emit) begin
          n.so_st = SO_DRIVE;
        end
      end
      SO_DRIVE: begin
        n.so_cnt = r.so_cnt + `ISP_CNT_W'(1);
        if (r.so_cnt == SO_CYC - `ISP_CNT_W'(1)) begin
          n.so_st = SO_IDLE;
        end
      end
      default: n.so_st = SO_IDLE;
    endcase
    if (fn6 != P6_SYNC) begin
      n.so_st = SO_IDLE; // leaving sync mode aborts a pulse
    end

    // pin drivers; sync mode drives only during its pulse
    // a released pin idles high behind its pull-up
    case (fn5)
      P5_OUTPUT: begin
        n.p5_oe = 1'b1;
        n.p5_o = out_lvl(r.cfg5[`ISP_F_OSEL_HI:`ISP_F_OSEL_LO], pwm5, inv5);
      end
      default: begin
        n.p5_oe = 1'b0;
        n.p5_o = 1'b1;
      end
    endcase
    case (fn6)
      P6_SYNC: begin
        n.p6_oe = (n.so_st == SO_DRIVE);
        n.p6_o = polar(1'b1, inv6); // active level of the pulse
      end
      P6_OUTPUT: begin
        n.p6_oe = 1'b1;
        n.p6_o = out_lvl(r.cfg6[`ISP_F_OSEL_HI:`ISP_F_OSEL_LO], pwm6, inv6);
      end
      default: begin
        n.p6_oe = 1'b0;
        n.p6_o = 1'b1;
      end
    endcase

    // sticky events; a read clears, a new event in that cycle survives
    // inhibit is reported once at its start, not for as long as it lasts
    ev[`ISP_S_TRIP] = trip;
    ev[`ISP_S_SYNC_IN] = sync_on;
    ev[`ISP_S_SYNC_OUT] = emit;
    ev[`ISP_S_INH] = n.level_inhibit_indication && !r.level_inhibit_indication;
    n.status = (rd_st ? '0 : r.status) | ev;
    n.irq = |(n.status & n.mask);

    // read data for the cycle after the strobe; unmapped reads zero
    // read data show registers as they stood before a same-cycle write
    n.rdata = 32'h0000_0000;
    if (RD) begin
      case (ADDR)
        `ISP_A_CFG5: n.rdata[`ISP_CFG_W-1:0] = r.cfg5;
        `ISP_A_CFG6: n.rdata[`ISP_CFG_W-1:0] = r.cfg6;
        `ISP_A_OUTCTL: begin
          n.rdata[`ISP_R_ON] = r.on;
          n.rdata[`ISP_R_DRV] = r.drive;
          n.rdata[`ISP_R_INH] = r.level_inhibit_indication;
          n.rdata[`ISP_R_PROT] = r.prot;
          n.rdata[`ISP_R_G5] = r.g5;
          n.rdata[`ISP_R_G6] = r.g6;
        end
        `ISP_A_STATUS: n.rdata[`ISP_ST_W-1:0] = r.status;
        `ISP_A_MASK: n.rdata[`ISP_ST_W-1:0] = r.mask;
        `ISP_A_PER5: n.rdata[15:0] = r.per5;
        `ISP_A_DUTY5: n.rdata[15:0] = r.duty5;
        `ISP_A_PER6: n.rdata[15:0] = r.per6;
        `ISP_A_DUTY6: n.rdata[15:0] = r.duty6;
        default: n.rdata = 32'h0000_0000;
      endcase
    end
  end

  // state register; reset leaves pin 5 in level inhibit, pin 6 in sync
  // fields with a reset macro, so_st and the idle-high pin outputs are named here
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      r <= '0;
      r.cfg5 <= `ISP_RST_CFG;
      r.cfg6 <= `ISP_RST_CFG;
      r.mask <= `ISP_RST_MASK;
      r.per5 <= `ISP_RST_PER;
      r.duty5 <= `ISP_RST_DUTY;
      r.per6 <= `ISP_RST_PER;
      r.duty6 <= `ISP_RST_DUTY;
      r.s5 <= `ISP_RST_SYNC;
      r.s6 <= `ISP_RST_SYNC;
      r.so_st <= SO_IDLE;
      r.p5_o <= 1'b1;
      r.p6_o <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // outputs straight from the state register
  // nothing is decoded on the way out, so the pins never glitch
  assign RDATA = r.rdata;
  assign IRQ = r.irq;
  assign OUT_ON = r.on;
  assign OUT_DRIVE = r.drive;
  assign INH_IND = r.level_inhibit_indication;
  assign PROT_IND = r.prot;
  assign P5_O = r.p5_o;
  assign P5_OE = r.p5_oe;
  assign P6_O = r.p6_o;
  assign P6_OE = r.p6_oe;
endmodule
`default_nettype wire

/* File: isp_monitor.sv */
// checker for the inhibit and sync pin block, bound to its top
`timescale 1ns/1ps
`default_nettype none
`include "isp_regs.svh"
module isp_monitor (
  input wire logic REF_CLK, // clock
  input wire logic RST, // sync reset
  input wire logic [7:0] ADDR, // address
  input wire logic [31:0] WDATA, // write data
  input wire logic WR, // write strobe
  input wire logic RD, // read strobe
  input wire logic [31:0] RDATA, // read data
  input wire logic IRQ, // interrupt
  input wire logic OUT_ON, // on state
  input wire logic OUT_DRIVE, // output allowed
  input wire logic INH_IND, // level inhibit shown
  input wire logic PROT_IND, // protection shown
  input wire logic P5_I, // pin5 in
  input wire logic P5_O, // pin5 out
  input wire logic P5_OE, // pin5 enable
  input wire logic P6_I, // pin6 in
  input wire logic P6_O, // pin6 out
  input wire logic P6_OE // pin6 enable
);
  logic [4:0] cfg5_reg;
  logic [4:0] cfg6_reg;
  logic [11:0] act_reg;
  logic [11:0] oe_reg;
  logic lvl5;
  logic latch5;
  logic act5;
  default clocking dcb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // decoded modes; low is the active level unless inverted
  assign lvl5 = cfg5_reg[1:0] == 2'h0;
  assign latch5 = cfg5_reg[1:0] == 2'h1;
  assign act5 = P5_I == cfg5_reg[2];
  // shadow the pin configs and count active and drive phases
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      cfg5_reg <= 5'h00;
      cfg6_reg <= 5'h00;
      act_reg <= 12'h000;
      oe_reg <= 12'h000;
    end else begin
      if (WR && ADDR == `ISP_A_CFG5) cfg5_reg <= WDATA[4:0];
      if (WR && ADDR == `ISP_A_CFG6) cfg6_reg <= WDATA[4:0];
      act_reg <= act5 ? act_reg + {11'h000, act_reg != 12'hFFF} : 12'h000;
      oe_reg <= P6_OE ? oe_reg + 12'h001 : 12'h000;
    end
  end
  a_inh_keeps_on: assert property (INH_IND |-> OUT_ON && !OUT_DRIVE)
    else $error("inhibit shown without on state or with drive");
  a_prot_blocks_on: assert property (PROT_IND |-> !OUT_ON)
    else $error("on state while protection shown");
  a_level_block: assert property ((lvl5 && OUT_ON && act5)[*5] |-> !OUT_DRIVE && INH_IND)
    else $error("active inhibit level did not stop the output");
  a_level_restore: assert property ((lvl5 && OUT_ON && !act5)[*5] |-> OUT_DRIVE)
    else $error("output not restored after inhibit");
  a_latch_hold: assert property (latch5 && $past(OUT_ON) && !$past(WR)
    && act_reg < 12'h2E4 |-> OUT_ON)
    else $error("on state lost without a qualifying pulse");
  a_latch_trip: assert property (latch5 && act_reg == 12'h2F3 && $past(OUT_ON, 5)
    |-> !OUT_ON && PROT_IND)
    else $error("qualifying pulse did not latch the output off");
  a_sync_emit: assert property (WR && ADDR == `ISP_A_OUTCTL && WDATA[1:0] == 2'h1
    && !OUT_ON && !PROT_IND && !P6_OE && cfg6_reg == 5'h00 |=> OUT_ON && P6_OE && !P6_O)
    else $error("local turn-on did not emit a sync pulse");
  a_sync_width: assert property ($fell(P6_OE) && cfg6_reg == 5'h00
    && $past(cfg6_reg) == 5'h00 |-> oe_reg == 12'h3E8)
    else $error("sync pulse width wrong");
  a_out_level: assert property ($stable(cfg5_reg)[*3] ##0 (cfg5_reg[1:0] == 2'h3
    && !cfg5_reg[4]) |-> P5_OE && P5_O == (cfg5_reg[3] ^ cfg5_reg[2]))
    else $error("static output level wrong");
  c_trip: cover property ($rose(PROT_IND));
  c_emit: cover property ($rose(P6_OE));
  c_inhibit: cover property ($rose(INH_IND));
endmodule
bind isp_top isp_monitor isp_monitor_inst (.REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .OUT_ON(OUT_ON),
  .OUT_DRIVE(OUT_DRIVE), .INH_IND(INH_IND), .PROT_IND(PROT_IND), .P5_I(P5_I),
  .P5_O(P5_O), .P5_OE(P5_OE), .P6_I(P6_I), .P6_O(P6_O), .P6_OE(P6_OE));
`default_nettype wire

/* File: isp_peer.sv */
// peer instrument pulling the inhibit and sync pins low, open drain
`timescale 1ns/1ps
`default_nettype none
module isp_peer (
  input wire logic clk, // system clock
  input wire logic p6, // resolved sync pin
  output logic dn5, // pulls inhibit pin low
  output logic dn6, // pulls sync pin low
  output logic [7:0] seen // sync pulses made by the far end
);
  logic p6_q;
  // own pulses are not counted, only falling edges from the other end;
  // one process owns the counter so it has a single driver
  initial begin
    dn5 = 1'b0;
    dn6 = 1'b0;
    seen = 8'h00;
    p6_q = 1'b1;
    forever begin
      @(posedge clk);
      p6_q <= p6;
      if (p6_q && !p6 && !dn6) seen <= seen + 8'h01;
    end
  end
  // low phase held for the whole count, then left to the pull-up
  task automatic pulse(input bit pin6, input int len);
    @(posedge clk);
    if (pin6) dn6 <= 1'b1; else dn5 <= 1'b1;
    repeat (len) @(posedge clk);
    dn5 <= 1'b0;
    dn6 <= 1'b0;
  endtask
  // steady level for the level and input cases
  task automatic hold5(input bit v);
    @(posedge clk);
    dn5 <= v;
  endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the inhibit and sync pin block
`timescale 1ns/1ps
`default_nettype none
`include "isp_regs.svh"
module tb_top;
  logic clk;
  logic rst;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic irq, on, drv, level_inhibit_indication, prot, p5_o, p5_oe, p6_o, p6_oe, dn5, dn6;
  logic [7:0] seen;
  int err_count = 0;
  int n_compared = 0;
  // pull-ups on both pins, wired with the peer
  wire p5 = (p5_oe ? p5_o : 1'b1) & ~dn5;
  wire p6 = (p6_oe ? p6_o : 1'b1) & ~dn6;
  isp_top isp_top_inst (.REF_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .IRQ(irq), .OUT_ON(on), .OUT_DRIVE(drv), .INH_IND(level_inhibit_indication),
    .PROT_IND(prot), .P5_I(p5), .P5_O(p5_o), .P5_OE(p5_oe), .P6_I(p6), .P6_O(p6_o),
    .P6_OE(p6_oe));
  isp_peer isp_peer_inst (.clk(clk), .p6(p6), .dn5(dn5), .dn6(dn6), .seen(seen));
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic finish_test();
    if (err_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rreg(input logic [7:0] a, input logic [31:0] e, input string what);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(what, e, rdata);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // bounded wait for the emitted sync pulse to end
  task automatic wait_idle();
    for (int k = 0; k < 1100 && p6_oe !== 1'b0; k++) @(negedge clk);
    chk("sync release", 0, p6_oe);
    if (p6_oe !== 1'b0) finish_test();
  endtask
  initial begin
    int k;
    int k6;
    rst <= 1'b1;
    wr <= 1'b0;
    rd <= 1'b0;
    addr <= 8'h00;
    wdata <= 32'h0000_0000;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    rreg(`ISP_A_CFG6, 0, "cfg6 reset");
    rreg(8'h40, 0, "unmapped");
    wreg(`ISP_A_OUTCTL, 1);
    cyc(1);
    chk("on", 1, on);
    chk("pin6 pulse", 0, p6);
    wait_idle();
    chk("pulses seen", 1, seen);
    wreg(`ISP_A_MASK, 4);
    cyc(2);
    chk("irq", 1, irq);
    wreg(`ISP_A_MASK, 1);
    cyc(2);
    chk("irq masked", 0, irq);
    wreg(`ISP_A_MASK, 4);
    rreg(`ISP_A_STATUS, 4, "status");
    cyc(2);
    chk("irq cleared", 0, irq);
    isp_peer_inst.hold5(1);
    cyc(5);
    chk("drive", 0, drv);
    chk("on kept", 1, on);
    chk("inh", 1, level_inhibit_indication);
    isp_peer_inst.hold5(0);
    cyc(5);
    chk("drive back", 1, drv);
    wreg(`ISP_A_CFG5, 4);
    cyc(5);
    chk("drive inv", 0, drv);
    isp_peer_inst.hold5(1);
    cyc(5);
    chk("drive inv low", 1, drv);
    isp_peer_inst.hold5(0);
    isp_peer_inst.pulse(1, 800);
    cyc(3);
    chk("sync while on", 1, on);
    wreg(`ISP_A_CFG5, 1);
    cyc(20);
    chk("latch idle", 1, on);
    isp_peer_inst.pulse(0, 600);
    cyc(3);
    chk("short pulse", 1, on);
    isp_peer_inst.pulse(0, 800);
    cyc(3);
    chk("latched off", 0, on);
    chk("prot", 1, prot);
    wreg(`ISP_A_OUTCTL, 1);
    cyc(2);
    chk("refused on", 0, on);
    wreg(`ISP_A_OUTCTL, 4);
    wreg(`ISP_A_OUTCTL, 1);
    cyc(2);
    chk("prot clear", 0, prot);
    chk("on again", 1, on);
    wait_idle();
    wreg(`ISP_A_OUTCTL, 2);
    isp_peer_inst.pulse(1, 800);
    cyc(3);
    chk("sync on", 1, on);
    chk("no echo", 0, p6_oe);
    // true and false, each with and without inversion, on both pins
    for (int i = 0; i < 4; i++) begin
      wreg(`ISP_A_CFG5, 3 | (i << 2));
      wreg(`ISP_A_CFG6, 2 | (i << 2));
      cyc(3);
      chk("pin5 out", i[0] ^ i[1], p5);
      chk("pin6 out", i[0] ^ i[1], p6);
    end
    wreg(`ISP_A_CFG5, 2);
    wreg(`ISP_A_CFG6, 5);
    isp_peer_inst.hold5(1);
    cyc(4);
    rreg(`ISP_A_OUTCTL, 32'h0000_0033, "gpio");
    isp_peer_inst.hold5(0);
    wreg(`ISP_A_PER5, 4);
    wreg(`ISP_A_DUTY5, 2);
    wreg(`ISP_A_PER6, 4);
    wreg(`ISP_A_DUTY6, 1);
    rreg(`ISP_A_PER6, 4, "per6");
    wreg(`ISP_A_CFG5, 32'h0000_0013);
    wreg(`ISP_A_CFG6, 32'h0000_0012);
    cyc(300);
    k = 0;
    k6 = 0;
    repeat (400) begin
      @(negedge clk);
      k += p5;
      k6 += p6;
    end
    chk("pwm high", 200, k);
    chk("pwm6 high", 300, k6);
    finish_test();
  end
endmodule
`default_nettype wire
